// File: lfs_consts.svh
// Named constants of the LED fault-status link, its device end and its controller end.
// Assumes it is included by bare name from every file that needs a figure.
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
// Common shift register: 48 channel bits and one selector bit on top.
`define LFS_CH 48
`define LFS_SR_BITS 49
`define LFS_SEL_BIT 48
// Rest levels of sclk, serial_in, latch_strobe, output_gate.
`define LFS_PIN_IDLE 4'h1
// Control word kind field and its codes.
`define LFS_KIND_LO 46
`define LFS_KIND_BRIGHT 2'h0
`define LFS_KIND_FUNC 2'h1
// Function-control field positions (two bits each).
`define LFS_FC_LOAD_LO 0
`define LFS_FC_OPEN_LO 2
`define LFS_FC_SHORT_LO 4
`define LFS_FC_PSAVE_LO 6
// Brightness field width and group count.
`define LFS_BC_W 7
`define LFS_GROUPS 3
// Status load select codes.
`define LFS_LOAD_OPEN 2'h1
`define LFS_LOAD_SHORT 2'h2
// Brightness scale in per mille: 60 plus 940 times code over 127.
`define LFS_BASE_PM 60
`define LFS_SPAN_PM 940
`define LFS_BC_MAX 127
// Clock rate and times.
`define LFS_CLK_MHZ 200
`define LFS_SETUP_NS 1000
`define LFS_SETUP_CYC ((`LFS_SETUP_NS * `LFS_CLK_MHZ + 999) / 1000)
`define LFS_VALID_NS 1000
`define LFS_VALID_CYC ((`LFS_VALID_NS * `LFS_CLK_MHZ + 999) / 1000)
// Controller register byte offsets.
`define LFS_A_TX_LO 8'h00
`define LFS_A_TX_HI 8'h04
`define LFS_A_CTRL 8'h08
`define LFS_A_CMD 8'h0C
`define LFS_A_RX_LO 8'h10
`define LFS_A_RX_HI 8'h14
`define LFS_A_STATUS 8'h18
`define LFS_A_IRQ_STAT 8'h1C
`define LFS_A_IRQ_CLR 8'h20
`define LFS_A_IRQ_EN 8'h24
// Interrupt bits: transfer done, gated on-time too short.
`define LFS_IRQ_DONE 0
`define LFS_IRQ_SHORT_ON 1
`define LFS_RESP_OKAY 2'h0
`define LFS_RESP_SLVERR 2'h2
`endif

// File: lfs_pkg.sv
// Types shared by both ends of the LED fault-status link.
// Assumes lfs_consts.svh supplies every numeric constant.
`default_nettype none
package lfs_pkg;
	// Controller serial engine states.
	typedef enum logic [2:0] {
		LFS_IDLE = 3'b000,
		LFS_LOW = 3'b001,
		LFS_HIGH = 3'b010,
		LFS_LATCH = 3'b011
	} lfs_state_t;
endpackage : lfs_pkg
`default_nettype wire

// File: lfs_link_if.sv
// Serial link between the display controller and the LED sink driver.
// Assumes both ends run on one aclk; link signals are plain logic levels.
`timescale 1ns/1ps
`default_nettype none
interface lfs_link_if;
	logic sclk; // Serial clock made by the controller.
	logic serial_in; // Data towards the device.
	logic latch_strobe; // Commits the shift register.
	logic output_gate; // High forces every output off.
	logic serial_out; // Data back from the device.
	modport dev(input sclk, input serial_in, input latch_strobe, input output_gate, output serial_out);
	modport ctl(output sclk, output serial_in, output latch_strobe, output output_gate, input serial_out);
endinterface : lfs_link_if
`default_nettype wire

// File: lfs_device.sv
// LED sink driver digital core: shift register, latches, fault-status holder.
// Assumes link inputs are asynchronous to aclk and comparator inputs are already clean.
//
// Behaviour
// R1 - On-off commit loads selected status afterwards
// R2 - Control commits never load status
// R3 - No reload until new bits shifted
// R4 - Controller waits setup before gate rise
// R5 - Open bit set at or below threshold
// R6 - Open bit zero for channels off
// R7 - Select 01b captures open results
// R8 - Controller ignores open results first microsecond
// R9 - Short bit set above threshold
// R10 - Short bit zero for channels off
// R11 - Select 10b captures short results
// R12 - Controller ignores short results first microsecond
// R13 - Outputs resume after power-save setup
// R14 - Status shifted out on serial output
// R15 - Current scales 0.06 plus 0.94 code/127
// R16 - Gate high forces outputs off
// R17 - On-off latch clears at power-up
// R18 - Other select codes keep holder
`timescale 1ns/1ps
`default_nettype none
`include "lfs_consts.svh"
module lfs_device
	import lfs_pkg::*;
#(
	parameter int SETUP_CYC = `LFS_SETUP_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Serial link.
	lfs_link_if.dev link,
	// Analog comparator results, one per channel.
	input wire logic [`LFS_CH-1:0] open_cmp,
	input wire logic [`LFS_CH-1:0] short_cmp,
	// Analog-side controls.
	output logic [`LFS_CH-1:0] sink_output,
	output logic [`LFS_GROUPS*10-1:0] current_pm,
	output logic [1:0] open_threshold_sel,
	output logic [1:0] short_threshold_sel,
	output logic powersave_active
);

	initial begin
		if (SETUP_CYC < 1) begin
			$error("SETUP_CYC must be at least one cycle.");
		end
	end

	// ****************************************
	// Input synchronisers
	// ****************************************

	// Order: sclk, serial_in, latch_strobe, output_gate.
	logic [3:0] raw;
	logic [3:0] s1_q; // First stage, read only by the second.
	logic [3:0] s2_q; // Second stage.
	logic [3:0] s3_q; // Third stage.
	logic [3:0] filt_q; // Accepted level once stages two and three agree.
	logic [3:0] rise; // One-cycle pulse on an accepted rising change.
	localparam logic [3:0] PIN_IDLE = `LFS_PIN_IDLE; // Stage reset values, so no false edge.

	assign raw = {link.sclk, link.serial_in, link.latch_strobe, link.output_gate};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			// Three stages; a glitch caught by the second alone never counts.
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_q[gi] <= PIN_IDLE[gi];
					s2_q[gi] <= PIN_IDLE[gi];
					s3_q[gi] <= PIN_IDLE[gi];
					filt_q[gi] <= PIN_IDLE[gi];
				end else begin
					s1_q[gi] <= raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						filt_q[gi] <= s3_q[gi];
					end
				end
			end
			assign rise[gi] = (s2_q[gi] == s3_q[gi]) && s3_q[gi] && !filt_q[gi];
		end
	endgenerate

	logic sclk_rise;
	logic sin_lvl;
	logic lat_rise;
	logic gate_rise;
	logic gate_lvl;
	assign sclk_rise = rise[3];
	assign sin_lvl = filt_q[2];
	assign lat_rise = rise[1];
	assign gate_rise = rise[0];
	assign gate_lvl = filt_q[0];

	// ****************************************
	// Shift register and latches
	// ****************************************

	logic [`LFS_SR_BITS-1:0] shift_q; // Common shift register.
	logic fresh_q; // New serial bits arrived since the last status load.
	logic [`LFS_CH-1:0] onoff_q; // On-off data latch.
	logic [`LFS_CH-1:0] holder_q; // Fault status holder.
	logic [`LFS_BC_W-1:0] bright_q [`LFS_GROUPS]; // Brightness codes per colour group.
	logic [1:0] load_sel_q; // status_load_select.
	logic [1:0] open_sel_q;
	logic [1:0] short_sel_q;
	logic [1:0] psave_sel_q; // powersave_select.
	logic is_ctrl;
	logic [1:0] kind;

	assign is_ctrl = shift_q[`LFS_SEL_BIT];
	assign kind = shift_q[`LFS_KIND_LO+:2];

	// Shift on sclk; on latch_strobe commit, then maybe reload with status.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= '0;
			fresh_q <= 1'b0;
		end else if (lat_rise) begin
			if (!is_ctrl && fresh_q) begin
				shift_q[`LFS_CH-1:0] <= holder_q; // see R1
				fresh_q <= 1'b0; // see R3
			end
		end else if (sclk_rise) begin
			// Shifting out the top bit is how status leaves the device.
			shift_q <= {shift_q[`LFS_SR_BITS-2:0], sin_lvl}; // see R14
			fresh_q <= 1'b1;
		end
	end

	// The latch takes the old shift contents; the status load above comes after.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			onoff_q <= '0; // see R17
		end else if (lat_rise && !is_ctrl) begin
			onoff_q <= shift_q[`LFS_CH-1:0]; // see R1
		end
	end

	// Control words write brightness or function control and leave shift_q alone.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int g = 0; g < `LFS_GROUPS; g++) begin
				bright_q[g] <= '0;
			end
			load_sel_q <= '0;
			open_sel_q <= '0;
			short_sel_q <= '0;
			psave_sel_q <= '0;
		end else if (lat_rise && is_ctrl) begin // see R2
			if (kind == `LFS_KIND_BRIGHT) begin
				for (int g = 0; g < `LFS_GROUPS; g++) begin
					bright_q[g] <= shift_q[g*`LFS_BC_W+:`LFS_BC_W];
				end
			end else if (kind == `LFS_KIND_FUNC) begin
				load_sel_q <= shift_q[`LFS_FC_LOAD_LO+:2];
				open_sel_q <= shift_q[`LFS_FC_OPEN_LO+:2];
				short_sel_q <= shift_q[`LFS_FC_SHORT_LO+:2];
				psave_sel_q <= shift_q[`LFS_FC_PSAVE_LO+:2];
			end
		end
	end

	// ****************************************
	// Fault detection and status holder
	// ****************************************

	logic [`LFS_CH-1:0] open_det; // open_detect per channel.
	logic [`LFS_CH-1:0] short_det; // short_detect per channel.
	// open_cmp is high at or below the open threshold; off channels read zero.
	assign open_det = open_cmp & onoff_q; // see R5 see R6
	// short_cmp is high above the short threshold; off channels read zero.
	assign short_det = short_cmp & onoff_q; // see R9 see R10

	// Capture on the gate's rising edge as the select field says.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			holder_q <= '0;
		end else if (gate_rise) begin
			unique case (load_sel_q)
				`LFS_LOAD_OPEN: holder_q <= open_det; // see R7
				`LFS_LOAD_SHORT: holder_q <= short_det; // see R11
				default: holder_q <= holder_q; // see R18
			endcase
		end
	end

	// ****************************************
	// Power save and outputs
	// ****************************************

	logic psave_now;
	logic [15:0] setup_q; // Cycles left before outputs may follow data again.
	// Power save: enabled by its select and all outputs latched off.
	assign psave_now = (psave_sel_q != 2'h0) && (onoff_q == '0);

	// Restart the setup wait whenever power save is in force.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			setup_q <= '0;
			powersave_active <= 1'b0;
		end else begin
			powersave_active <= psave_now;
			if (psave_now) begin
				setup_q <= 16'(SETUP_CYC);
			end else if (setup_q != 16'h0) begin
				setup_q <= setup_q - 16'h1;
			end
		end
	end

	// Outputs follow the latch and the gate level once setup has elapsed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sink_output <= '0;
		end else if (gate_lvl || setup_q != 16'h0 || psave_now) begin
			sink_output <= '0; // see R16 see R13
		end else begin
			sink_output <= onoff_q; // see R16 see R13
		end
	end

	// Current per group in per mille of maximum.
	generate
		for (gi = 0; gi < `LFS_GROUPS; gi++) begin : g_scale
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					current_pm[gi*10+:10] <= 10'(`LFS_BASE_PM);
				end else begin
					current_pm[gi*10+:10] <= 10'(`LFS_BASE_PM + (`LFS_SPAN_PM * 32'(bright_q[gi])) / `LFS_BC_MAX); // see R15
				end
			end
		end
	endgenerate

	assign open_threshold_sel = open_sel_q;
	assign short_threshold_sel = short_sel_q;
	assign link.serial_out = shift_q[`LFS_SEL_BIT]; // see R14

endmodule : lfs_device
`default_nettype wire

// File: lfs_controller.sv
// Display controller end: AXI4-Lite registers drive the serial link and the gate.
// Assumes the device samples link levels with aclk and needs DIV cycles per half period.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_consts.svh"
module lfs_controller
	import lfs_pkg::*;
#(
	parameter int DIV = 4,
	parameter int SETUP_CYC = `LFS_SETUP_CYC,
	parameter int VALID_CYC = `LFS_VALID_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave.
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Interrupt.
	output logic irq,
	// Serial link.
	lfs_link_if.ctl link
);

	initial begin
		if (DIV < 5 || DIV > 255) begin
			$error("DIV must lie in 5..255 so the device can see each half period.");
		end
	end

	// ****************************************
	// Register slave
	// ****************************************

	logic [7:0] awaddr_q;
	logic aw_have_q;
	logic [31:0] wdata_q;
	logic w_have_q;
	logic [`LFS_SR_BITS-1:0] tx_q; // Word to send, top bit first.
	logic [`LFS_SR_BITS-1:0] rx_q; // Word returned from serial_out.
	logic gate_req_q; // Software's wish for output_gate.
	logic start_q; // One-cycle start pulse.
	logic latch_req_q; // Strobe the latch after the shift.
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic [1:0] irq_set;
	logic short_on_q; // Last capture saw too short an on-time.
	logic busy;
	logic wr_go;
	lfs_state_t state_q;

	assign s_awready = !aw_have_q && !s_bvalid;
	assign s_wready = !w_have_q && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign wr_go = aw_have_q && w_have_q && !s_bvalid;
	assign busy = (state_q != LFS_IDLE) || start_q;

	// Address and data may arrive in either order; the answer follows both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= `LFS_RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				awaddr_q <= s_awaddr;
				aw_have_q <= 1'b1;
			end
			if (s_wvalid && s_wready) begin
				wdata_q <= s_wdata;
				w_have_q <= 1'b1;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (awaddr_q > `LFS_A_IRQ_EN || awaddr_q[1:0] != 2'h0) ? `LFS_RESP_SLVERR : `LFS_RESP_OKAY;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Register writes; byte strobes are ignored, a word write is assumed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_q <= '0;
			gate_req_q <= 1'b1;
			start_q <= 1'b0;
			latch_req_q <= 1'b0;
			irq_en_q <= '0;
		end else begin
			start_q <= 1'b0;
			if (wr_go) begin
				unique case (awaddr_q)
					`LFS_A_TX_LO: tx_q[31:0] <= wdata_q;
					`LFS_A_TX_HI: tx_q[`LFS_SR_BITS-1:32] <= wdata_q[`LFS_SR_BITS-33:0];
					`LFS_A_CTRL: gate_req_q <= wdata_q[0];
					`LFS_A_CMD: begin
						// A start while busy is dropped, but its latch bit is still taken; software polls busy first.
						start_q <= wdata_q[0] && !busy;
						latch_req_q <= wdata_q[1];
					end
					`LFS_A_IRQ_EN: irq_en_q <= wdata_q[1:0];
					default: ;
				endcase
			end
		end
	end

	// Sticky interrupt bits: a new event wins over a clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_go && awaddr_q == `LFS_A_IRQ_CLR) ? wdata_q[1:0] : 2'h0)) | irq_set;
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= `LFS_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp <= `LFS_RESP_OKAY;
			unique case (s_araddr)
				`LFS_A_TX_LO: s_rdata <= tx_q[31:0];
				`LFS_A_TX_HI: s_rdata <= {15'h0, tx_q[`LFS_SR_BITS-1:32]};
				`LFS_A_CTRL: s_rdata <= {31'h0, gate_req_q};
				`LFS_A_RX_LO: s_rdata <= rx_q[31:0];
				`LFS_A_RX_HI: s_rdata <= {15'h0, rx_q[`LFS_SR_BITS-1:32]};
				`LFS_A_STATUS: s_rdata <= {29'h0, short_on_q, link.output_gate, busy};
				`LFS_A_IRQ_STAT: s_rdata <= {30'h0, irq_stat_q};
				`LFS_A_IRQ_EN: s_rdata <= {30'h0, irq_en_q};
				default: begin
					s_rdata <= '0;
					s_rresp <= `LFS_RESP_SLVERR;
				end
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Serial engine
	// ****************************************

	logic so1_q; // First stage, read only by the second.
	logic so2_q;
	logic so3_q;
	logic serial_out_q; // Accepted serial_out level.
	logic [7:0] div_q;
	logic [5:0] bit_q;
	logic div_end;
	assign div_end = (div_q == 8'(DIV - 1));

	// serial_out comes from the device's clock domain view; filter like a pin.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			so1_q <= 1'b0;
			so2_q <= 1'b0;
			so3_q <= 1'b0;
			serial_out_q <= 1'b0;
		end else begin
			so1_q <= link.serial_out;
			so2_q <= so1_q;
			so3_q <= so2_q;
			if (so2_q == so3_q) begin
				serial_out_q <= so3_q;
			end
		end
	end

	// Shift 49 bits top first, sampling serial_out before each rising sclk.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= LFS_IDLE;
			div_q <= '0;
			bit_q <= '0;
			rx_q <= '0;
			link.sclk <= 1'b0;
			link.serial_in <= 1'b0;
			link.latch_strobe <= 1'b0;
		end else begin
			div_q <= div_end ? 8'h0 : div_q + 8'h1;
			unique case (state_q)
				LFS_IDLE: begin
					div_q <= '0;
					if (start_q) begin
						link.serial_in <= tx_q[`LFS_SEL_BIT];
						bit_q <= '0;
						state_q <= LFS_LOW;
					end
				end
				LFS_LOW: if (div_end) begin
					rx_q <= {rx_q[`LFS_SR_BITS-2:0], serial_out_q}; // see R14
					link.sclk <= 1'b1;
					state_q <= LFS_HIGH;
				end
				LFS_HIGH: if (div_end) begin
					link.sclk <= 1'b0;
					if (bit_q == 6'(`LFS_SR_BITS - 1)) begin
						link.latch_strobe <= latch_req_q;
						state_q <= latch_req_q ? LFS_LATCH : LFS_IDLE;
					end else begin
						bit_q <= bit_q + 6'h1;
						link.serial_in <= tx_q[6'(`LFS_SEL_BIT - 1) - bit_q];
						state_q <= LFS_LOW;
					end
				end
				LFS_LATCH: if (div_end) begin
					link.latch_strobe <= 1'b0;
					state_q <= LFS_IDLE;
				end
				default: state_q <= LFS_IDLE;
			endcase
		end
	end
	assign irq_set[`LFS_IRQ_DONE] = (state_q == LFS_HIGH && div_end && bit_q == 6'(`LFS_SR_BITS - 1) && !latch_req_q)
		|| (state_q == LFS_LATCH && div_end);

	// ****************************************
	// Gate, setup wait and on-time check
	// ****************************************

	logic [15:0] hold_q; // Cycles before a gate rise is allowed.
	logic [15:0] on_q; // Cycles the gate has been low.
	logic gate_up;
	assign gate_up = gate_req_q && !link.output_gate && hold_q == 16'h0;
	assign irq_set[`LFS_IRQ_SHORT_ON] = gate_up && on_q < 16'(VALID_CYC);

	// An all-zero on-off word may put the device in power save; wait after leaving it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_q <= '0;
			on_q <= '0;
			short_on_q <= 1'b0;
			link.output_gate <= 1'b1;
		end else begin
			if (state_q == LFS_LATCH && div_end && !tx_q[`LFS_SEL_BIT]) begin
				hold_q <= 16'(SETUP_CYC); // see R4
			end else if (hold_q != 16'h0) begin
				hold_q <= hold_q - 16'h1;
			end
			if (!gate_req_q) begin
				link.output_gate <= 1'b0;
			end else if (gate_up) begin
				link.output_gate <= 1'b1; // see R4
				short_on_q <= on_q < 16'(VALID_CYC); // see R8 see R12
			end
			if (link.output_gate) begin
				on_q <= '0;
			end else if (on_q != 16'hFFFF) begin
				on_q <= on_q + 16'h1;
			end
		end
	end

endmodule : lfs_controller
`default_nettype wire

// File: lfs_link_monitor.sv
// Checker for the LED fault-status link between the controller and the device.
// Assumes the controller runs with DIV = 5 and the device syncs link inputs in three stages.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_consts.svh"
module lfs_link_monitor (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Link signals.
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic latch_strobe,
	input wire logic output_gate,
	input wire logic serial_out,
	// Device outputs.
	input wire logic [`LFS_CH-1:0] sink_output
);
	// ***********************
	// Properties
	// ***********************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// The strobe stands DIV cycles, then drops.
	sequence s_latch_pulse;
		latch_strobe [*5] ##1 !latch_strobe;
	endsequence
	// Gate held long enough for the sync stages to pass it.
	sequence s_gate_held;
		output_gate [*8];
	endsequence
	property p_reset_idle;
		$rose(aresetn) |-> output_gate && !sclk && !latch_strobe && sink_output == '0;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("link or outputs not idle after reset");
	property p_gate_off;
		s_gate_held |-> sink_output == '0;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("output on while gate high");
	property p_gate_rise;
		$rose(output_gate) |-> ##[1:8] sink_output == '0;
	endproperty
	a_gate_rise: assert property (p_gate_rise) else $error("outputs not off after gate rise");
	property p_latch_width;
		$rose(latch_strobe) |-> s_latch_pulse;
	endproperty
	a_latch_width: assert property (p_latch_width) else $error("latch strobe width wrong");
	property p_sclk_high;
		$rose(sclk) |-> sclk [*5] ##1 !sclk;
	endproperty
	a_sclk_high: assert property (p_sclk_high) else $error("serial clock high phase wrong");
	property p_sclk_low;
		$fell(sclk) |-> !sclk [*5];
	endproperty
	a_sclk_low: assert property (p_sclk_low) else $error("serial clock low phase short");
	property p_din_stable;
		sclk |-> $stable(serial_in);
	endproperty
	a_din_stable: assert property (p_din_stable) else $error("serial data moved while clock high");
	property p_no_shift_in_latch;
		latch_strobe |-> !sclk;
	endproperty
	a_no_shift_in_latch: assert property (p_no_shift_in_latch) else $error("shift during latch");
	property p_dout_quiet;
		(!sclk && !latch_strobe) [*8] |-> $stable(serial_out);
	endproperty
	a_dout_quiet: assert property (p_dout_quiet) else $error("serial output moved with link idle");
endmodule : lfs_link_monitor
`default_nettype wire

// File: testbench.sv
// Self-checking bench: controller and device joined by the link interface.
// Assumes short setup and validity counts stand in for the long ones.
`timescale 1ns/1ps
`default_nettype none
`include "lfs_consts.svh"
`define TB_CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
	// ***********************
	// Signals
	// ***********************
	localparam logic [47:0] ONOFF = 48'h0000_FFFF_00F0; // Channels switched on.
	localparam logic [47:0] OPENV = 48'hF0F0_F0F0_F0F0; // Open comparator pattern.
	localparam logic [47:0] SHORTV = 48'h0FF0_0FF0_0FF0; // Short comparator pattern.
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, powersave_active;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, d;
	logic [1:0] s_bresp, s_rresp, r, open_threshold_sel, short_threshold_sel;
	logic [47:0] open_cmp, short_cmp, sink_output;
	logic [29:0] current_pm;
	logic [48:0] rx;
	int fail_count = 0;
	int n_compared = 0;
	lfs_link_if lfs_link_if_i();
	lfs_device #(.SETUP_CYC(4)) lfs_device_i(.aclk(aclk), .aresetn(aresetn), .link(lfs_link_if_i.dev),
		.open_cmp(open_cmp), .short_cmp(short_cmp), .sink_output(sink_output), .current_pm(current_pm),
		.open_threshold_sel(open_threshold_sel), .short_threshold_sel(short_threshold_sel),
		.powersave_active(powersave_active));
	lfs_controller #(.DIV(5), .SETUP_CYC(4), .VALID_CYC(8)) lfs_controller_i(.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
		.s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .irq(irq),
		.link(lfs_link_if_i.ctl));
	lfs_link_monitor lfs_link_monitor_i(.aclk(aclk), .aresetn(aresetn), .sclk(lfs_link_if_i.sclk),
		.serial_in(lfs_link_if_i.serial_in), .latch_strobe(lfs_link_if_i.latch_strobe),
		.output_gate(lfs_link_if_i.output_gate), .serial_out(lfs_link_if_i.serial_out),
		.sink_output(sink_output));
	// Clock at 200 MHz and all inputs defined at time zero.
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_araddr, s_wdata} = 48'h0;
		open_cmp = OPENV;
		short_cmp = SHORTV;
	end
	always #2.5 aclk = ~aclk;
	// ***********************
	// Bus and link tasks
	// ***********************
	// Write: address and data offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_awready) begin
				aw_done = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (!w_done && s_wready) begin
				w_done = 1'b1;
				s_wvalid <= 1'b0;
			end
		end
		s_bready <= 1'b1;
		do @(posedge aclk); while (s_bvalid !== 1'b1);
		resp = s_bresp;
		s_bready <= 1'b0;
	endtask : wr
	// Read: ready for data is held until the answer is sampled.
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		do @(posedge aclk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		s_rready <= 1'b1;
		do @(posedge aclk); while (s_rvalid !== 1'b1);
		v = s_rdata;
		resp = s_rresp;
		s_rready <= 1'b0;
	endtask : rd
	// One 49-bit shift and latch; returns what the device shifted back.
	task automatic xfer(input logic [48:0] w, output logic [48:0] back);
		logic [31:0] lo, hi;
		logic [1:0] rr;
		wr(`LFS_A_TX_LO, w[31:0], rr);
		wr(`LFS_A_TX_HI, {15'h0000, w[48:32]}, rr);
		wr(`LFS_A_CMD, 32'h0000_0003, rr);
		do rd(`LFS_A_STATUS, lo, rr); while (lo[0] !== 1'b0);
		`TB_CHK("done_irq", 1'b1, irq)
		wr(`LFS_A_IRQ_CLR, 32'h0000_0001, rr);
		`TB_CHK("irq_cleared", 1'b0, irq)
		rd(`LFS_A_RX_LO, lo, rr);
		rd(`LFS_A_RX_HI, hi, rr);
		back = {hi[16:0], lo};
	endtask : xfer
	// Sets the requested gate level and lets it settle through the sync stages.
	task automatic gate(input logic lvl);
		logic [1:0] rr;
		wr(`LFS_A_CTRL, {31'h0, lvl}, rr);
		repeat (20) @(posedge aclk);
	endtask : gate
	// Select a status source, pulse the gate, then read the holder back.
	task automatic capture(input logic [1:0] sel, input logic [47:0] exp);
		logic [48:0] fw, back;
		fw = {1'b1, `LFS_KIND_FUNC, 38'h0, 2'h0, 2'h3, 2'h2, sel};
		xfer(fw, back);
		gate(1'b0);
		`TB_CHK("sink_on", ONOFF, sink_output)
		gate(1'b1);
		`TB_CHK("sink_off", 48'h0, sink_output)
		xfer({1'b0, ONOFF}, back);
		`TB_CHK("control_kept", fw, back)
		xfer({1'b0, ONOFF}, back);
		`TB_CHK("status_read", {1'b0, exp}, back)
		$display("test capture select %0h done", sel);
	endtask : capture
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	// ***********************
	// Tests
	// ***********************
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`TB_CHK("pm_reset", {3{10'h03C}}, current_pm)
		`TB_CHK("gate_idle", 1'b1, lfs_link_if_i.output_gate)
		`TB_CHK("sink_reset", 48'h0, sink_output)
		rd(`LFS_A_CTRL, d, r);
		`TB_CHK("ctrl_reset", 32'h0000_0001, d)
		rd(8'h28, d, r);
		`TB_CHK("rd_unmapped", `LFS_RESP_SLVERR, r)
		`TB_CHK("rd_unmapped_data", 32'h0, d)
		wr(8'h2C, 32'hFFFF_FFFF, r);
		`TB_CHK("wr_unmapped", `LFS_RESP_SLVERR, r)
		wr(`LFS_A_IRQ_EN, 32'h0000_0001, r);
		$display("test reset and registers done");
		xfer({1'b0, ONOFF}, rx);
		capture(2'h1, OPENV & ONOFF);
		`TB_CHK("open_sel", 2'h2, open_threshold_sel)
		`TB_CHK("short_sel", 2'h3, short_threshold_sel)
		capture(2'h2, SHORTV & ONOFF);
		open_cmp <= ~OPENV;
		short_cmp <= ~SHORTV;
		capture(2'h0, SHORTV & ONOFF);
		xfer({1'b1, `LFS_KIND_BRIGHT, 25'h0, 7'h7F, 7'h00, 7'h40}, rx);
		repeat (10) @(posedge aclk);
		`TB_CHK("current_scale", {10'h3E8, 10'h03C, 10'h215}, current_pm)
		$display("test brightness done");
		wr(`LFS_A_CTRL, 32'h0, r);
		wr(`LFS_A_CTRL, 32'h0000_0001, r);
		repeat (20) @(posedge aclk);
		rd(`LFS_A_IRQ_STAT, d, r);
		`TB_CHK("short_on_flag", 1'b1, d[1])
		`TB_CHK("short_on_masked", 1'b0, irq)
		xfer({1'b1, `LFS_KIND_FUNC, 38'h0, 2'h1, 6'h0}, rx);
		xfer(49'h0, rx);
		`TB_CHK("psave", 1'b1, powersave_active)
		$display("test gate window and power save done");
		close_out;
	end
	// Watchdog: the whole sequence needs well under 20000 cycles.
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		close_out;
	end
endmodule : testbench
`default_nettype wire
